// >>> include/nvram_host_pkg.sv
// constants for the bytewide nonvolatile ram host controller
package nvram_host_pkg;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int ROW_BYTES = 8;
    // bus timing limits in ns
    localparam int T_CE_NS = 70;
    localparam int T_CA_NS = 70;
    localparam int PRECHARGE_NS = 60;
    localparam int T_AH_NS = 15;
    localparam int T_DS_NS = 30;
    localparam int T_WP_NS = 40;
    localparam int T_HZ_NS = 15;
    // least times round up
    localparam int ACCESS_CYC = (T_CE_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int ACTIVE_CYC = (T_CA_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int PRECHARGE_CYC = (PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int ADDR_HOLD_CYC = (T_AH_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int DATA_SETUP_CYC = (T_DS_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int WRITE_PULSE_CYC = (T_WP_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int RELEASE_CYC = (T_HZ_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int CNT_W = 8;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;
endpackage : nvram_host_pkg

// >>> src/nvram_sync_reset.sv
// reset release synchroniser
`timescale 1ns/1ps
module nvram_sync_reset (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    output logic o_rst_n
);
    logic meta_reg;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_reg <= 1'b0;
            o_rst_n <= 1'b0;
        end else begin
            meta_reg <= 1'b1;
            o_rst_n <= meta_reg;
        end
    end
endmodule : nvram_sync_reset

// >>> src/nvram_host_ctrl.sv
// host controller driving a bytewide nonvolatile ram bus
`timescale 1ns/1ps
module nvram_host_ctrl #(
    parameter int ACCESS_CYC = nvram_host_pkg::ACCESS_CYC,
    parameter int PRECHARGE_CYC = nvram_host_pkg::PRECHARGE_CYC,
    parameter int ADDR_HOLD_CYC = nvram_host_pkg::ADDR_HOLD_CYC,
    parameter int DATA_SETUP_CYC = nvram_host_pkg::DATA_SETUP_CYC,
    parameter int WRITE_PULSE_CYC = nvram_host_pkg::WRITE_PULSE_CYC,
    parameter int RELEASE_CYC = nvram_host_pkg::RELEASE_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [nvram_host_pkg::ADDR_W-1:0] i_req_addr,
    input wire logic [nvram_host_pkg::DATA_W-1:0] i_req_wdata,
    input wire logic i_supply_ok,
    input wire logic [nvram_host_pkg::DATA_W-1:0] i_dq,
    output logic o_req_ready,
    output logic o_rd_valid,
    output logic [nvram_host_pkg::DATA_W-1:0] o_rd_data,
    output logic o_wr_done,
    output logic [nvram_host_pkg::ADDR_W-1:0] o_addr,
    output logic o_chip_sel_n,
    output logic o_wr_strobe_n,
    output logic o_out_en_n,
    output logic [nvram_host_pkg::DATA_W-1:0] o_dq,
    output logic o_dq_oe
);
    localparam logic [nvram_host_pkg::CNT_W-1:0] ACC_LAST =
        nvram_host_pkg::CNT_W'(ACCESS_CYC - 1);
    localparam logic [nvram_host_pkg::CNT_W-1:0] PC_LAST =
        nvram_host_pkg::CNT_W'(PRECHARGE_CYC - 1);
    localparam logic [nvram_host_pkg::CNT_W-1:0] AH_LAST =
        nvram_host_pkg::CNT_W'(ADDR_HOLD_CYC - 1);
    localparam logic [nvram_host_pkg::CNT_W-1:0] DS_LAST =
        nvram_host_pkg::CNT_W'(DATA_SETUP_CYC - 1);
    localparam logic [nvram_host_pkg::CNT_W-1:0] WP_LAST =
        nvram_host_pkg::CNT_W'(WRITE_PULSE_CYC - 1);
    localparam logic [nvram_host_pkg::CNT_W-1:0] HZ_LAST =
        nvram_host_pkg::CNT_W'(RELEASE_CYC - 1);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_RELEASE,
        ST_PRECHARGE
    } state_t;

    logic rst_n;
    state_t state_reg;
    logic [nvram_host_pkg::CNT_W-1:0] cnt_reg;
    logic is_write_reg;
    logic start;

    // ------------------------------------------------------------
    // reset
    // ------------------------------------------------------------
    nvram_sync_reset u_sync_reset (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .o_rst_n(rst_n)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // last cycle of a read access, data valid on the pins
    function automatic logic read_done(
        input state_t st,
        input logic [nvram_host_pkg::CNT_W-1:0] cnt
    );
        return st == ST_READ && cnt == ACC_LAST;
    endfunction : read_done

    // write held for access time, pulse width and data setup
    function automatic logic write_done(
        input state_t st,
        input logic [nvram_host_pkg::CNT_W-1:0] cnt
    );
        return st == ST_WRITE && cnt >= ACC_LAST && cnt >= WP_LAST
            && cnt >= DS_LAST;
    endfunction : write_done

    // a request is taken only while ready shows; no cycle starts
    // while the supply is out of tolerance
    assign start = (state_reg == ST_IDLE) && o_req_ready
        && i_req_valid && i_supply_ok;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            is_write_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    cnt_reg <= '0;
                    if (start) begin
                        is_write_reg <= i_req_write;
                        // write strobe falls with select: select-led write
                        state_reg <= i_req_write ? ST_WRITE : ST_READ;
                    end
                end
                ST_READ: begin
                    // select low just long enough for data; bounded low
                    if (cnt_reg == ACC_LAST) begin
                        cnt_reg <= '0;
                        state_reg <= ST_RELEASE;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                ST_WRITE: begin
                    // active time covers pulse width and data setup
                    if (write_done(state_reg, cnt_reg)) begin
                        cnt_reg <= '0;
                        state_reg <= ST_PRECHARGE;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                ST_RELEASE: begin
                    // select high: precharge counted from here too
                    if (cnt_reg == HZ_LAST) begin
                        state_reg <= ST_PRECHARGE;
                    end
                    cnt_reg <= cnt_reg + 1'b1;
                end
                ST_PRECHARGE: begin
                    if (cnt_reg >= PC_LAST) begin
                        cnt_reg <= '0;
                        state_reg <= ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    cnt_reg <= '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // bus strobes
    // ------------------------------------------------------------
    // each access gets its own select fall, never tied low
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_chip_sel_n <= 1'b1;
        end else if (start) begin
            o_chip_sel_n <= 1'b0;
        end else if (read_done(state_reg, cnt_reg)
            || write_done(state_reg, cnt_reg)) begin
            o_chip_sel_n <= 1'b1;
        end
    end

    // write strobe falls with select and rises with it
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_wr_strobe_n <= 1'b1;
        end else if (start && i_req_write) begin
            o_wr_strobe_n <= 1'b0;
        end else if (state_reg != ST_WRITE
            || write_done(state_reg, cnt_reg)) begin
            o_wr_strobe_n <= 1'b1;
        end
    end

    // output enable only for reads
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_out_en_n <= 1'b1;
        end else if (start && !i_req_write) begin
            o_out_en_n <= 1'b0;
        end else if (read_done(state_reg, cnt_reg)) begin
            o_out_en_n <= 1'b1;
        end
    end

    // address and write data held for the whole cycle
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_addr <= nvram_host_pkg::ADDR_RESET;
            o_dq <= nvram_host_pkg::DATA_RESET;
            o_dq_oe <= 1'b0;
        end else begin
            if (start) begin
                o_addr <= i_req_addr;
                o_dq <= i_req_wdata;
            end
            // drive data only during writes, device holds off
            if (start && i_req_write) begin
                o_dq_oe <= 1'b1;
            end else if (state_reg == ST_PRECHARGE
                || state_reg == ST_IDLE) begin
                o_dq_oe <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // user answers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_req_ready <= 1'b0;
            o_rd_valid <= 1'b0;
            o_wr_done <= 1'b0;
            o_rd_data <= nvram_host_pkg::DATA_RESET;
        end else begin
            o_req_ready <= (state_reg == ST_IDLE) && !start;
            // data sampled after access time has passed
            o_rd_valid <= read_done(state_reg, cnt_reg);
            o_wr_done <= write_done(state_reg, cnt_reg);
            if (read_done(state_reg, cnt_reg)) begin
                o_rd_data <= i_dq;
            end
        end
    end
endmodule : nvram_host_ctrl

// >>> sim/nvram_host_chk.sv
// pin protocol checker for the host controller
`timescale 1ns/1ps
module nvram_host_chk #(
    parameter int ACCESS_CYC = nvram_host_pkg::ACCESS_CYC,
    parameter int PRECHARGE_CYC = nvram_host_pkg::PRECHARGE_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [14:0] i_req_addr,
    input wire logic i_supply_ok,
    input wire logic o_req_ready,
    input wire logic o_rd_valid,
    input wire logic o_wr_done,
    input wire logic [14:0] o_addr,
    input wire logic o_chip_sel_n,
    input wire logic o_wr_strobe_n,
    input wire logic o_out_en_n,
    input wire logic [7:0] o_dq,
    input wire logic o_dq_oe
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    logic [7:0] hi_reg;
    logic [7:0] lo_reg;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) hi_reg <= 8'hff;
        else if (!o_chip_sel_n) hi_reg <= 8'h00;
        else if (hi_reg != 8'hff) hi_reg <= hi_reg + 8'h01;
    end
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) lo_reg <= 8'h00;
        else if (o_chip_sel_n) lo_reg <= 8'h00;
        else lo_reg <= lo_reg + 8'h01;
    end
    sequence take_s;
        o_req_ready && i_req_valid && i_supply_ok;
    endsequence
    addr_hold_a: assert property (
        $fell(o_chip_sel_n) |=> $stable(o_addr) [*3])
        else $error("address moved within hold");
    addr_take_a: assert property (
        take_s |=> $fell(o_chip_sel_n) && o_addr == $past(i_req_addr))
        else $error("select or address not from request");
    data_setup_a: assert property (
        $rose(o_wr_strobe_n) |-> o_dq_oe && $past(o_dq_oe, 6)
        && $stable(o_dq) && $past(o_dq, 6) == o_dq)
        else $error("write data not held through setup");
    precharge_a: assert property (
        $fell(o_chip_sel_n) |-> hi_reg >= PRECHARGE_CYC)
        else $error("select high too short");
    low_time_a: assert property (
        !o_chip_sel_n |-> lo_reg < ACCESS_CYC)
        else $error("select low too long");
    fresh_sel_a: assert property (
        $fell(o_wr_strobe_n) || $fell(o_out_en_n) |-> $fell(o_chip_sel_n))
        else $error("strobe without select fall");
    supply_a: assert property (
        !i_supply_ok && o_chip_sel_n |=> o_chip_sel_n)
        else $error("access started with supply low");
    no_fight_a: assert property (
        !o_out_en_n |-> !o_dq_oe && o_wr_strobe_n)
        else $error("host drives data while output enabled");
    rd_answer_a: assert property (
        take_s ##0 !i_req_write |-> ##15 o_rd_valid)
        else $error("read answer late");
    wr_answer_a: assert property (
        take_s ##0 i_req_write |-> ##15 o_wr_done)
        else $error("write answer late");
endmodule : nvram_host_chk
bind nvram_host_ctrl nvram_host_chk #(.ACCESS_CYC(ACCESS_CYC),
    .PRECHARGE_CYC(PRECHARGE_CYC)) chk_i (.i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst), .i_req_valid(i_req_valid), .i_req_write(i_req_write),
    .i_req_addr(i_req_addr), .i_supply_ok(i_supply_ok),
    .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
    .o_wr_done(o_wr_done), .o_addr(o_addr), .o_chip_sel_n(o_chip_sel_n),
    .o_wr_strobe_n(o_wr_strobe_n), .o_out_en_n(o_out_en_n),
    .o_dq(o_dq), .o_dq_oe(o_dq_oe));

// >>> sim/nvram_model.sv
// behavioural bytewide nonvolatile ram on the far side
`timescale 1ns/1ps
module nvram_model #(
    parameter int ACCESS_NS = 50
) (
    input wire logic [14:0] i_addr,
    input wire logic i_chip_sel_n,
    input wire logic i_wr_strobe_n,
    input wire logic i_out_en_n,
    input wire logic [7:0] i_dq,
    output logic [7:0] o_dq,
    output logic o_dq_oe
);
    logic [7:0] mem [0:32767];
    int row_wear [0:4095];
    logic [14:0] addr_reg;
    logic wr_reg = 1'b0;
    logic valid_reg = 1'b0;
    always @(negedge i_chip_sel_n) begin
        addr_reg = i_addr;
        wr_reg = !i_wr_strobe_n;
        row_wear[i_addr[14:3]]++;
        valid_reg = 1'b0;
        valid_reg <= #(ACCESS_NS) 1'b1;
    end
    always @(negedge i_wr_strobe_n) if (!i_chip_sel_n) wr_reg = 1'b1;
    always @(posedge i_chip_sel_n or posedge i_wr_strobe_n) begin
        if (wr_reg) mem[addr_reg] = i_dq;
        wr_reg = 1'b0;
    end
    // undriven lines show the inverse so stale data never passes
    assign o_dq_oe = !i_chip_sel_n && !i_out_en_n && !wr_reg && valid_reg;
    assign o_dq = o_dq_oe ? mem[addr_reg] : ~mem[addr_reg];
endmodule : nvram_model

// >>> sim/test_bytewide_nv_ram_bus_cycle.sv
// self-checking bench for the host controller
`timescale 1ns/1ps
module test_bytewide_nv_ram_bus_cycle;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic valid = 1'b0;
    logic wr = 1'b0;
    logic sup = 1'b1;
    logic [14:0] addr = 15'h0000;
    logic [14:0] m_addr;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata, h_dq, m_dq, bus;
    logic rv, wd, ready, sel_n, we_n, oe_n, h_oe, m_oe;
    logic fight = 1'b0;
    logic drove = 1'b0;
    logic [7:0] shadow [0:32767];
    logic [14:0] used [$];
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int falls = 0;
    int ops = 0;
    int seed = 937;
    int r;
    int row0 = 0;
    assign bus = h_oe ? h_dq : m_dq;
    initial forever #2.5 clk = ~clk;
    always @(negedge sel_n) falls++;
    // sticky flags: both sides driving, and the memory ever answering
    always @(negedge clk) begin
        if (h_oe && m_oe) fight = 1'b1;
        if (m_oe) drove = 1'b1;
    end
    always @(posedge clk) if (++cycles == 5000) begin
        fail_count++;
        finish_test();
    end
    nvram_host_ctrl nvram_host_ctrl_i (.i_ref_clk(clk), .i_nrst(nrst),
        .i_req_valid(valid), .i_req_write(wr), .i_req_addr(addr),
        .i_req_wdata(wdata), .i_supply_ok(sup), .i_dq(bus),
        .o_req_ready(ready), .o_rd_valid(rv), .o_rd_data(rdata),
        .o_wr_done(wd), .o_addr(m_addr), .o_chip_sel_n(sel_n),
        .o_wr_strobe_n(we_n), .o_out_en_n(oe_n), .o_dq(h_dq),
        .o_dq_oe(h_oe));
    nvram_model nvram_model_i (.i_addr(m_addr), .i_chip_sel_n(sel_n),
        .i_wr_strobe_n(we_n), .i_out_en_n(oe_n), .i_dq(bus),
        .o_dq(m_dq), .o_dq_oe(m_oe));
    function automatic logic [14:0] answer_cycles();
        return 15'(nvram_host_pkg::ACCESS_CYC);
    endfunction : answer_cycles
    task automatic check(input string nm, input logic [14:0] s, e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic op(input logic w, input logic [14:0] a,
        input logic [7:0] d);
        int n;
        n = 0;
        valid = 1'b1;
        wr = w;
        addr = a;
        wdata = d;
        while (ready !== 1'b1 && n++ < 100) @(negedge clk);
        @(posedge clk);
        @(negedge clk);
        valid = 1'b0;
        ops++;
        if (w) shadow[a] = d;
        if (a[14:3] == 12'h000) row0++;
        n = 0;
        while ((w ? wd : rv) !== 1'b1 && n++ < 40) @(negedge clk);
        check("answer latency", 15'(n), answer_cycles());
        if (!w) check("read data", {7'h00, rdata}, {7'h00, shadow[a]});
    endtask : op
    task automatic finish_test();
        if (fail_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        // row edges and the top address back to back
        op(1'b1, 15'h7fff, 8'ha5);
        op(1'b1, 15'h0007, 8'h3c);
        op(1'b1, 15'h0008, 8'hc3);
        op(1'b0, 15'h7fff, 8'h00);
        op(1'b0, 15'h0007, 8'h00);
        op(1'b0, 15'h0008, 8'h00);
        for (int i = 0; i < 30; i++) begin
            r = $random(seed);
            op(1'b1, r[14:0], r[22:15]);
            used.push_back(r[14:0]);
        end
        foreach (used[i]) op(1'b0, used[i], 8'h00);
        sup = 1'b0;
        valid = 1'b1;
        repeat (30) @(negedge clk);
        check("select low supply", {14'h0000, sel_n}, 15'h0001);
        valid = 1'b0;
        sup = 1'b1;
        check("select falls", 15'(falls), 15'(ops));
        check("bus fight", {14'h0000, fight}, 15'h0000);
        check("memory drove", {14'h0000, drove}, 15'h0001);
        check("row wear", 15'(nvram_model_i.row_wear[0]),
            15'(row0));
        finish_test();
    end
endmodule : test_bytewide_nv_ram_bus_cycle
